// >>> hw/cwcp_pkg.sv
/*
 Constants and types shared by both ends of the configuration-word and
 code-protection block. Assumes a 100 MHz clock on both ends.
*/
package cwcp_pkg;
  // ****************************************************************
  // Widths and memory sizes
  // ****************************************************************
  localparam int WORD_W = 14;
  localparam int CMD_W = 6;
  localparam int PMEM_WORDS = 2048;
  localparam int DMEM_WORDS = 64;
  localparam int PIDX_W = 11;
  localparam int DIDX_W = 6;
  localparam int CKS_W = 16;
  // ****************************************************************
  // Configuration space map
  // ****************************************************************
  localparam logic [13:0] CFG_BASE = 14'h2000;
  localparam logic [13:0] DEVID_ADDR = 14'h2006;
  localparam logic [13:0] CONFW_ADDR = 14'h2007;
  localparam logic [12:0] ID_LAST = 13'h0003;
  localparam logic [12:0] TEST_LAST = 13'h000F;
  localparam logic [13:0] WORD_BLANK = 14'h3FFF;
  localparam logic [7:0] DATA_BLANK = 8'hFF;
  localparam logic [13:0] CONFW_RESET = 14'h3FFF;
  localparam logic [13:0] RSVD_MASK = 14'h0200;
  localparam logic [13:0] CKS_CFG_MASK = 14'h3DFF;
  localparam logic [3:0] ID_NIB_MASK = 4'hF;
  localparam logic [10:0] PROT_2K_HI = 11'h400;
  localparam logic [10:0] PROT_MID = 11'h200;
  // ****************************************************************
  // Configuration word fields
  // ****************************************************************
  localparam int CP_HI_POS = 12;
  localparam int CP_LO_POS = 10;
  localparam int DPROT_POS = 8;
  localparam int LOWV_POS = 7;
  localparam int BOR_POS = 6;
  localparam int XRST_POS = 5;
  localparam int OSC2_POS = 4;
  localparam int PUT_N_POS = 3;
  localparam int WDOG_POS = 2;
  // ****************************************************************
  // Command codes, low four bits decoded
  // ****************************************************************
  localparam logic [3:0] C_LOAD_CFG = 4'h0;
  localparam logic [3:0] C_CLR_STEP1 = 4'h1;
  localparam logic [3:0] C_LOAD_PROG = 4'h2;
  localparam logic [3:0] C_LOAD_DATA = 4'h3;
  localparam logic [3:0] C_READ_PROG = 4'h4;
  localparam logic [3:0] C_READ_DATA = 4'h5;
  localparam logic [3:0] C_INC = 4'h6;
  localparam logic [3:0] C_CLR_STEP2 = 4'h7;
  localparam logic [3:0] C_BEGIN = 4'h8;
  localparam logic [3:0] C_BULK_PROG = 4'h9;
  localparam logic [3:0] C_BULK_DATA = 4'hB;
  localparam logic [5:0] CMD_BEGIN_FULL = 6'h08;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 100;
  localparam int CLEAR_WAIT_MS = 10;
  localparam int CLEAR_WAIT_CYC = CLEAR_WAIT_MS * 1000 * CLK_MHZ;
  localparam int WAIT_W = 24;
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    OSC_LP, OSC_XT, OSC_HS, OSC_EXT_IN,
    OSC_IRC_IO, OSC_IRC_CLKOUT, OSC_XRES_IO, OSC_XRES_CLKOUT
  } cwcp_osc_t;
  typedef enum logic [2:0] {
    OP_SEND, OP_CLEAR, OP_CKS_INIT, OP_CKS_WORD, OP_CKS_CFG, OP_CKS_ID
  } cwcp_op_t;
  typedef enum {ST_IDLE, ST_SEQ, ST_WAIT} cwcp_state_t;
endpackage : cwcp_pkg

// >>> hw/cwcp_if.sv
/*
 Command link between the programmer end and the device end.
 Assumes both ends share CLK and RSTN; commands arrive already framed.
*/
`timescale 1ns/1ps
interface cwcp_if;
  import cwcp_pkg::*;
  logic cmd_valid;
  logic [CMD_W-1:0] cmd_code;
  logic [WORD_W-1:0] cmd_data;
  logic rsp_valid;
  logic [WORD_W-1:0] rsp_data;
  modport dev (input cmd_valid, input cmd_code, input cmd_data,
               output rsp_valid, output rsp_data);
  modport prg (output cmd_valid, output cmd_code, output cmd_data,
               input rsp_valid, input rsp_data);
endinterface : cwcp_if

// >>> hw/cwcp_device.sv
/*
 Device end: program, data, ID and configuration storage, code
 protection and configuration-word decode. Assumes the programmer
 sends one command per cycle at most and waits out programming time.
*/
`timescale 1ns/1ps
module cwcp_device
  import cwcp_pkg::*;
#(
  parameter logic PROG_2K = 1'b1,
  // Arbitrary identification values, not those of any real part.
  parameter logic [13:0] DEVID_2K = 14'h1A50,
  parameter logic [13:0] DEVID_1K = 14'h1A30
) (
  input wire logic CLK,
  input wire logic RSTN,
  cwcp_if.dev LINK,
  input wire logic MASTER_CLEAR_PIN_N,
  input wire logic LOW_VOLT_PROG_PIN,
  output logic LV_PROG_ENTRY,
  output logic HV_PROG_REQUIRED,
  output logic BROWNOUT_RESET_EN,
  output logic POWERUP_TIMER_EN,
  output logic MASTER_CLEAR_IS_RESET,
  output logic EXT_RESET_N,
  output logic WATCHDOG_EN,
  output cwcp_osc_t OSC_MODE,
  output logic CLKOUT_EN,
  output logic INT_OSC_OFF,
  output logic CODE_PROTECTED
);
  // ****************************************************************
  // Storage and state
  // ****************************************************************
  logic [13:0] pmem_ff [PMEM_WORDS];
  logic [7:0] dmem_ff [DMEM_WORDS];
  logic [13:0] id_ff [4];
  logic [13:0] cfg_ff;
  logic [13:0] pc_ff;
  logic [13:0] latch_ff;
  logic [1:0] latch_kind_ff;
  logic bulk_prog_ff, bulk_data_ff, step1_ff, step2_ff;
  logic rsp_valid_ff;
  logic [13:0] rsp_data_ff;
  logic [1:0] xrst_sync_ff, lowv_sync_ff;

  function automatic logic [1:0] prot_rank(input logic [13:0] w);
    logic [1:0] cp;
    cp = (w[CP_HI_POS+:2] == w[CP_LO_POS+:2]) ? w[CP_HI_POS+:2] : 2'b11;
    if (PROG_2K) begin
      prot_rank = ~cp;
    end else begin
      prot_rank = (cp == 2'b00) ? 2'd2 : (cp == 2'b01) ? 2'd1 : 2'd0;
    end
  endfunction : prot_rank

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire [3:0] op = LINK.cmd_code[3:0];
  wire cmd = LINK.cmd_valid;
  wire in_cfg = pc_ff[13];
  wire [12:0] cfg_off = pc_ff[12:0];
  wire [10:0] pidx = PROG_2K ? pc_ff[10:0] : {1'b0, pc_ff[9:0]};
  wire [5:0] didx = pc_ff[5:0];
  wire [1:0] rank = prot_rank(cfg_ff);
  wire cp_on = (rank != 2'd0);
  wire dp_on = ~cfg_ff[DPROT_POS];
  wire [10:0] prot_base = (rank == 2'd1) ? (PROG_2K ? PROT_2K_HI : PROT_MID) :
                          (rank == 2'd2 && PROG_2K) ? PROT_MID : 11'h000;
  wire prot_hit = cp_on && (pidx >= prot_base);
  wire is_id = in_cfg && (cfg_off <= ID_LAST);
  wire is_confw = (pc_ff == CONFW_ADDR);
  wire [13:0] cfg_new = latch_ff | RSVD_MASK;
  wire [1:0] rank_new = prot_rank(cfg_new);
  wire cp_drop = (rank_new < rank);
  wire dp_drop = dp_on && cfg_new[DPROT_POS];
  wire begin_cmd = cmd && (op == C_BEGIN);
  wire do_clear = begin_cmd && step2_ff && is_confw;
  wire mem_locked = cp_on;
  wire do_bulk_p = begin_cmd && bulk_prog_ff && !mem_locked;
  wire do_bulk_d = begin_cmd && bulk_data_ff && !mem_locked && !dp_on;
  wire wr_any = begin_cmd && !do_clear && !bulk_prog_ff && !bulk_data_ff;
  wire wr_prog = wr_any && (latch_kind_ff == 2'd1) && !in_cfg && !mem_locked;
  wire wr_data = wr_any && (latch_kind_ff == 2'd2) && !mem_locked && !dp_on;
  wire wr_id = wr_any && (latch_kind_ff != 2'd2) && is_id;
  wire wr_cfg = wr_any && (latch_kind_ff != 2'd2) && is_confw;
  wire wipe_p = do_clear || do_bulk_p || (wr_cfg && cp_drop);
  wire wipe_d = do_clear || do_bulk_d || (wr_cfg && dp_drop);
  wire wipe_id = do_bulk_p && in_cfg && (cfg_off <= TEST_LAST);
  logic [13:0] cfg_rd;
  logic [13:0] rd_word;

  always_comb begin
    case (cfg_off)
      13'h0000, 13'h0001, 13'h0002, 13'h0003: cfg_rd = id_ff[cfg_off[1:0]];
      DEVID_ADDR[12:0]: cfg_rd = PROG_2K ? DEVID_2K : DEVID_1K;
      CONFW_ADDR[12:0]: cfg_rd = cfg_ff;
      default: cfg_rd = WORD_BLANK;
    endcase
  end

  assign rd_word = (op == C_READ_DATA) ? (dp_on ? 14'h0000 : {6'h00, dmem_ff[didx]}) :
                   in_cfg ? cfg_rd : (prot_hit ? 14'h0000 : pmem_ff[pidx]);

  // ****************************************************************
  // Command sequencing
  // ****************************************************************
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pc_ff <= 14'h0000;
      latch_ff <= WORD_BLANK;
      latch_kind_ff <= 2'd0;
      bulk_prog_ff <= 1'b0;
      bulk_data_ff <= 1'b0;
      step1_ff <= 1'b0;
      step2_ff <= 1'b0;
    end else if (cmd) begin
      step1_ff <= (op == C_CLR_STEP1);
      step2_ff <= (op == C_CLR_STEP2) && step1_ff;
      case (op)
        C_LOAD_CFG: begin
          pc_ff <= CFG_BASE;
          latch_ff <= LINK.cmd_data;
          latch_kind_ff <= 2'd0;
        end
        C_LOAD_PROG: begin
          latch_ff <= LINK.cmd_data;
          latch_kind_ff <= 2'd1;
        end
        C_LOAD_DATA: begin
          latch_ff <= LINK.cmd_data;
          latch_kind_ff <= 2'd2;
        end
        C_INC: pc_ff <= {pc_ff[13], pc_ff[12:0] + 13'h0001};
        C_BULK_PROG: bulk_prog_ff <= 1'b1;
        C_BULK_DATA: bulk_data_ff <= 1'b1;
        C_BEGIN: begin
          bulk_prog_ff <= 1'b0;
          bulk_data_ff <= 1'b0;
        end
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Non-volatile storage updates
  // ****************************************************************
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cfg_ff <= CONFW_RESET;
    end else if (do_clear) begin
      cfg_ff <= CONFW_RESET;
    end else if (wr_cfg) begin
      cfg_ff <= cfg_new;
    end
  end

  // Erase beats a word write: a wipe in the same cycle leaves all blank.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < PMEM_WORDS; i++) pmem_ff[i] <= WORD_BLANK;
    end else if (wipe_p) begin
      for (int i = 0; i < PMEM_WORDS; i++) pmem_ff[i] <= WORD_BLANK;
    end else if (wr_prog) begin
      pmem_ff[pidx] <= latch_ff;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < DMEM_WORDS; i++) dmem_ff[i] <= DATA_BLANK;
    end else if (wipe_d) begin
      for (int i = 0; i < DMEM_WORDS; i++) dmem_ff[i] <= DATA_BLANK;
    end else if (wr_data) begin
      dmem_ff[didx] <= latch_ff[7:0];
    end
  end

  // ID words survive every wipe except a bulk program erase in test space.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < 4; i++) id_ff[i] <= WORD_BLANK;
    end else if (wipe_id) begin
      for (int i = 0; i < 4; i++) id_ff[i] <= WORD_BLANK;
    end else if (wr_id) begin
      id_ff[cfg_off[1:0]] <= latch_ff;
    end
  end

  // ****************************************************************
  // Read answer
  // ****************************************************************
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= 14'h0000;
    end else begin
      rsp_valid_ff <= cmd && (op == C_READ_PROG || op == C_READ_DATA);
      if (cmd && (op == C_READ_PROG || op == C_READ_DATA)) begin
        rsp_data_ff <= rd_word;
      end
    end
  end
  assign LINK.rsp_valid = rsp_valid_ff;
  assign LINK.rsp_data = rsp_data_ff;

  // ****************************************************************
  // Pin synchronisers and configuration decode
  // ****************************************************************
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      xrst_sync_ff <= 2'b11;
      lowv_sync_ff <= 2'b00;
    end else begin
      xrst_sync_ff <= {xrst_sync_ff[0], MASTER_CLEAR_PIN_N};
      lowv_sync_ff <= {lowv_sync_ff[0], LOW_VOLT_PROG_PIN};
    end
  end

  wire [2:0] osc_sel = {cfg_ff[OSC2_POS], cfg_ff[1:0]};
  wire rc_mode = osc_sel[2];
  assign LV_PROG_ENTRY = cfg_ff[LOWV_POS] & lowv_sync_ff[1];
  assign HV_PROG_REQUIRED = ~cfg_ff[LOWV_POS];
  assign BROWNOUT_RESET_EN = cfg_ff[BOR_POS];
  assign POWERUP_TIMER_EN = ~cfg_ff[PUT_N_POS] | cfg_ff[BOR_POS];
  assign MASTER_CLEAR_IS_RESET = cfg_ff[XRST_POS];
  assign EXT_RESET_N = cfg_ff[XRST_POS] ? xrst_sync_ff[1] : 1'b1;
  assign WATCHDOG_EN = cfg_ff[WDOG_POS];
  assign OSC_MODE = cwcp_osc_t'(osc_sel);
  assign CLKOUT_EN = rc_mode & osc_sel[0];
  assign INT_OSC_OFF = cfg_ff[XRST_POS] & rc_mode;
  assign CODE_PROTECTED = cp_on;
endmodule : cwcp_device

// >>> hw/cwcp_programmer.sv
/*
 Programmer end: forwards raw commands, runs the protection-clearing
 sequence and accumulates the checksum. Assumes the user waits for
 USER_BUSY low before each request.
*/
`timescale 1ns/1ps
module cwcp_programmer
  import cwcp_pkg::*;
#(
  parameter int WAIT_CYCLES = CLEAR_WAIT_CYC
) (
  input wire logic CLK,
  input wire logic RSTN,
  cwcp_if.prg LINK,
  input wire logic USER_VALID,
  input wire cwcp_op_t USER_OP,
  input wire logic [5:0] USER_CMD,
  input wire logic [13:0] USER_DATA,
  input wire logic [13:0] USER_ADDR,
  output logic USER_BUSY,
  output logic USER_RVALID,
  output logic [13:0] USER_RDATA,
  output logic [15:0] CHECKSUM
);
  cwcp_state_t state_ff;
  logic [3:0] step_ff;
  logic [WAIT_W-1:0] wait_ff;
  logic cmd_valid_ff;
  logic [5:0] cmd_code_ff;
  logic [13:0] cmd_data_ff;
  logic [15:0] sum_ff, id_pack_ff;
  logic [13:0] limit_ff;
  logic [1:0] nib_ff;
  logic [13:0] rdata_ff;
  logic rvalid_ff;

  // ****************************************************************
  // Clearing sequence table
  // ****************************************************************
  logic [5:0] seq_code;
  always_comb begin
    case (step_ff)
      4'd0: seq_code = {2'b00, C_LOAD_CFG};
      4'd8, 4'd11: seq_code = {2'b00, C_CLR_STEP1};
      4'd9, 4'd12: seq_code = {2'b00, C_CLR_STEP2};
      4'd10: seq_code = CMD_BEGIN_FULL;
      default: seq_code = {2'b00, C_INC};
    endcase
  end
  wire start = USER_VALID && (state_ff == ST_IDLE);
  wire [WAIT_W-1:0] wait_last = WAIT_W'(WAIT_CYCLES - 1);
  wire [15:0] cfg_term = {2'b00, USER_DATA & CKS_CFG_MASK};
  wire [15:0] id_next = {id_pack_ff[11:0], USER_DATA[3:0] & ID_NIB_MASK};
  wire in_range = (USER_ADDR <= limit_ff);

  // ****************************************************************
  // Command issue
  // ****************************************************************
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_ff <= ST_IDLE;
      step_ff <= 4'd0;
      wait_ff <= '0;
      cmd_valid_ff <= 1'b0;
      cmd_code_ff <= 6'h00;
      cmd_data_ff <= 14'h0000;
    end else begin
      cmd_valid_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (start && USER_OP == OP_SEND) begin
            cmd_valid_ff <= 1'b1;
            cmd_code_ff <= USER_CMD;
            cmd_data_ff <= USER_DATA;
          end else if (start && USER_OP == OP_CLEAR) begin
            state_ff <= ST_SEQ;
            step_ff <= 4'd0;
          end
        end
        ST_SEQ: begin
          cmd_valid_ff <= 1'b1;
          cmd_code_ff <= seq_code;
          cmd_data_ff <= WORD_BLANK;
          step_ff <= step_ff + 4'd1;
          if (step_ff == 4'd10) begin
            state_ff <= ST_WAIT;
            wait_ff <= '0;
          end else if (step_ff == 4'd12) begin
            state_ff <= ST_IDLE;
          end
        end
        ST_WAIT: begin
          wait_ff <= wait_ff + 1'b1;
          if (wait_ff == wait_last) begin
            state_ff <= ST_SEQ;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Checksum and read return
  // ****************************************************************
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sum_ff <= 16'h0000;
      id_pack_ff <= 16'h0000;
      limit_ff <= 14'h3FFF;
      nib_ff <= 2'd0;
    end else if (start) begin
      case (USER_OP)
        OP_CKS_INIT: begin
          sum_ff <= 16'h0000;
          limit_ff <= USER_DATA;
          nib_ff <= 2'd0;
        end
        OP_CKS_WORD: if (in_range) sum_ff <= sum_ff + {2'b00, USER_DATA};
        OP_CKS_CFG: sum_ff <= sum_ff + cfg_term;
        OP_CKS_ID: begin
          id_pack_ff <= id_next;
          nib_ff <= nib_ff + 2'd1;
          if (nib_ff == 2'd3) sum_ff <= sum_ff + id_next;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 14'h0000;
    end else begin
      rvalid_ff <= LINK.rsp_valid;
      if (LINK.rsp_valid) rdata_ff <= LINK.rsp_data;
    end
  end

  assign LINK.cmd_valid = cmd_valid_ff;
  assign LINK.cmd_code = cmd_code_ff;
  assign LINK.cmd_data = cmd_data_ff;
  assign USER_BUSY = (state_ff != ST_IDLE);
  assign USER_RVALID = rvalid_ff;
  assign USER_RDATA = rdata_ff;
  assign CHECKSUM = sum_ff;
endmodule : cwcp_programmer

// >>> tb/cwcp_chk.sv
/*
 Assertions on the command link joining the programmer end to the device end.
 Assumes one clock and one active-low asynchronous reset for both ends.
*/
`timescale 1ns/1ps
module cwcp_chk
  import cwcp_pkg::*;
#(
  parameter logic [13:0] DEVID = 14'h1A50
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic cmd_valid,
  input wire logic [CMD_W-1:0] cmd_code,
  input wire logic [WORD_W-1:0] cmd_data,
  input wire logic rsp_valid,
  input wire logic [WORD_W-1:0] rsp_data
);
  // ****************************************************************
  // Address tracking
  // ****************************************************************
  // The address is rebuilt from the commands alone, so a device that
  // loses its own address cannot hide the fault from these checks.
  logic [13:0] pc_ff;
  logic [13:0] nxt_pc;
  wire [3:0] op = cmd_code[3:0];
  wire rd_prog = cmd_valid && (op == C_READ_PROG);
  wire rd_any = rd_prog || (cmd_valid && (op == C_READ_DATA));
  wire step1 = cmd_valid && (op == C_CLR_STEP1);
  wire step2 = cmd_valid && (op == C_CLR_STEP2);
  wire go_cmd = cmd_valid && (op == C_BEGIN);
  assign nxt_pc = !cmd_valid ? pc_ff : (op == C_LOAD_CFG) ? CFG_BASE :
                  (op == C_INC) ? pc_ff + 14'h0001 : pc_ff;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pc_ff <= 14'h0000;
    end else begin
      pc_ff <= nxt_pc;
    end
  end
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  a_read_answer: assert property (rd_any |=> rsp_valid)
    else $error("read command not answered one cycle later");
  a_rsp_cause: assert property (rsp_valid |-> $past(rd_any))
    else $error("answer without a read command");
  a_rsp_hold: assert property (!rsp_valid |-> $stable(rsp_data))
    else $error("read word changed without an answer");
  a_devid_value: assert property (rd_prog && pc_ff == DEVID_ADDR |=> rsp_data == DEVID)
    else $error("identification word read wrong");
  a_rsvd_one: assert property (rd_prog && pc_ff == CONFW_ADDR |=> rsp_data[9])
    else $error("reserved configuration bit read as zero");
  a_clear_pair: assert property (step1 |=> step2)
    else $error("first clearing step not followed by the second");
  a_clear_at_cfg: assert property (step1 |-> pc_ff == CONFW_ADDR)
    else $error("clearing step issued away from the configuration word");
  a_begin_code: assert property (go_cmd |-> cmd_code == CMD_BEGIN_FULL)
    else $error("begin command sent with a wrong full code");
  a_clear_wait: assert property (step2 ##1 go_cmd |=> !cmd_valid [*8])
    else $error("command sent during the clearing wait");
endmodule : cwcp_chk

// >>> tb/testbench.sv
/*
 Self-checking bench: both ends joined by the link, user side driven here.
 Assumes the package and the interface compile before this file.
*/
`timescale 1ns/1ps
module testbench;
  import cwcp_pkg::*;
  // Arbitrary identification value.
  localparam logic [13:0] DEVID_VAL = 14'h1A50;
  logic clk, rst_n, xrst_pin_n, lowv_pin, user_valid;
  cwcp_op_t user_op;
  logic [5:0] user_cmd;
  logic [13:0] user_data, user_addr, user_rdata;
  logic lv_entry, hv_req, bor_en, put_en, xrst_sel, ext_rst_n, wdog_en;
  logic clkout_en, osc_off, code_prot, user_busy, user_rvalid;
  cwcp_osc_t osc_mode;
  logic [15:0] checksum;
  int err_count, checks_done;
  logic [31:0] seed;
  logic [13:0] exp_q[$];
  wire [12:0] dec_seen = {lv_entry, hv_req, bor_en, put_en, xrst_sel, ext_rst_n, wdog_en,
                          osc_mode, clkout_en, osc_off, code_prot};
  cwcp_if link();
  cwcp_device #(.DEVID_2K(DEVID_VAL)) i_cwcp_device (.CLK(clk), .RSTN(rst_n), .LINK(link),
    .MASTER_CLEAR_PIN_N(xrst_pin_n), .LOW_VOLT_PROG_PIN(lowv_pin), .LV_PROG_ENTRY(lv_entry),
    .HV_PROG_REQUIRED(hv_req), .BROWNOUT_RESET_EN(bor_en), .POWERUP_TIMER_EN(put_en),
    .MASTER_CLEAR_IS_RESET(xrst_sel), .EXT_RESET_N(ext_rst_n), .WATCHDOG_EN(wdog_en),
    .OSC_MODE(osc_mode), .CLKOUT_EN(clkout_en), .INT_OSC_OFF(osc_off),
    .CODE_PROTECTED(code_prot));
  cwcp_programmer #(.WAIT_CYCLES(20)) i_cwcp_programmer (.CLK(clk), .RSTN(rst_n),
    .LINK(link), .USER_VALID(user_valid), .USER_OP(user_op), .USER_CMD(user_cmd),
    .USER_DATA(user_data), .USER_ADDR(user_addr), .USER_BUSY(user_busy),
    .USER_RVALID(user_rvalid), .USER_RDATA(user_rdata), .CHECKSUM(checksum));
  cwcp_chk #(.DEVID(DEVID_VAL)) i_cwcp_chk (.CLK(clk), .RSTN(rst_n),
    .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code), .cmd_data(link.cmd_data),
    .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [12:0] dec(input logic [13:0] d, input logic m, input logic l);
    logic eq;
    eq = (d[13:12] == d[11:10]);
    return {d[7] & l, ~d[7], d[6], ~d[3] | d[6], d[5], d[5] ? m : 1'b1, d[2], d[4],
            d[1:0], d[4] & d[0], d[5] & d[4], eq && (d[13:12] != 2'b11)};
  endfunction : dec
  task automatic report_and_stop();
    if (err_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic req(input cwcp_op_t op, input logic [5:0] c, input logic [13:0] d,
                     input logic [13:0] a);
    int n;
    n = 0;
    @(posedge clk);
    while (user_busy !== 1'b0) begin
      n++;
      if (n > 400) begin
        err_count++;
        report_and_stop();
      end
      @(posedge clk);
    end
    user_valid <= 1'b1;
    user_op <= op;
    user_cmd <= c;
    user_data <= d;
    user_addr <= a;
    @(posedge clk);
    user_valid <= 1'b0;
  endtask : req
  task automatic cmd(input logic [5:0] c, input logic [13:0] d);
    req(OP_SEND, c, d, 14'h0000);
  endtask : cmd
  task automatic rd(input logic [5:0] c, input logic [13:0] e);
    exp_q.push_back(e);
    cmd(c, 14'h0000);
  endtask : rd
  task automatic prog_cfg(input logic [13:0] d);
    cmd(6'h00, d);
    repeat (7) cmd(6'h06, 14'h0000);
    cmd(CMD_BEGIN_FULL, 14'h0000);
    rd(6'h04, d | RSVD_MASK);
  endtask : prog_cfg
  always @(posedge clk) begin
    if (user_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_count++;
        $display("wrong value read data expected none seen %h", user_rdata);
      end else begin
        chk("read data", {2'b00, exp_q.pop_front()}, {2'b00, user_rdata});
      end
    end
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    int i;
    int n;
    logic [13:0] d, a, c;
    logic [2:0] os;
    rst_n = 1'b0;
    xrst_pin_n = 1'b1;
    lowv_pin = 1'b0;
    user_valid = 1'b0;
    user_op = OP_SEND;
    user_cmd = 6'h00;
    user_data = 14'h0000;
    user_addr = 14'h0000;
    err_count = 0;
    checks_done = 0;
    seed = 32'd92693;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("decode at reset", {3'b000, dec(CONFW_RESET, 1'b1, 1'b0)}, {3'b000, dec_seen});
    cmd(6'h00, 14'h0A5C);
    cmd(CMD_BEGIN_FULL, 14'h0000);
    rd(6'h04, 14'h0A5C);
    repeat (6) cmd(6'h06, 14'h0000);
    cmd(6'h02, 14'h0000);
    cmd(CMD_BEGIN_FULL, 14'h0000);
    rd(6'h04, DEVID_VAL);
    for (i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      os = (i < 8) ? i[2:0] : seed[11:9];
      d = {(i < 8) ? 4'hF : {i[1:0], i[1:0]}, seed[0], seed[1], seed[4:2], os[2], seed[6:5],
           os[1:0]};
      xrst_pin_n <= seed[7];
      lowv_pin <= seed[8];
      prog_cfg(d);
      @(posedge clk);
      chk("decode", {3'b000, dec(d, seed[7], seed[8])}, {3'b000, dec_seen});
    end
    prog_cfg(14'h3FFF);
    cmd(6'h03, 14'h00A5);
    cmd(CMD_BEGIN_FULL, 14'h0000);
    rd(6'h05, 14'h00A5);
    prog_cfg(14'h17FF);
    cmd(6'h03, 14'h005A);
    cmd(CMD_BEGIN_FULL, 14'h0000);
    rd(6'h05, 14'h00A5);
    prog_cfg(14'h16FF);
    rd(6'h05, 14'h0000);
    req(OP_CLEAR, 6'h00, 14'h0000, 14'h0000);
    rd(6'h04, 14'h3FFF);
    rd(6'h05, 14'h00FF);
    chk("protected flag", 16'h0000, {15'h0000, code_prot});
    cmd(6'h03, 14'h0033);
    cmd(CMD_BEGIN_FULL, 14'h0000);
    prog_cfg(14'h3EFF);
    prog_cfg(14'h3FFF);
    rd(6'h05, 14'h00FF);
    cmd(6'h00, 14'h3FFF);
    rd(6'h04, 14'h0A5C);
    cmd(6'h09, 14'h0000);
    cmd(CMD_BEGIN_FULL, 14'h0000);
    rd(6'h04, 14'h3FFF);
    cmd(6'h03, 14'h0033);
    cmd(CMD_BEGIN_FULL, 14'h0000);
    cmd(6'h0B, 14'h0000);
    cmd(CMD_BEGIN_FULL, 14'h0000);
    rd(6'h05, 14'h00FF);
    seed = lfsr(seed);
    a = seed[13:0];
    c = seed[27:14];
    req(OP_CKS_INIT, 6'h00, 14'h01FF, 14'h0000);
    req(OP_CKS_WORD, 6'h00, a, 14'h01FF);
    req(OP_CKS_WORD, 6'h00, 14'h3FFF, 14'h0200);
    req(OP_CKS_CFG, 6'h00, c, 14'h0000);
    for (i = 1; i < 5; i++) begin
      req(OP_CKS_ID, 6'h00, 14'(i), 14'h0000);
    end
    @(posedge clk);
    @(posedge clk);
    chk("checksum", {2'b00, a} + {2'b00, c & CKS_CFG_MASK} + 16'h1234, checksum);
    n = 0;
    while (exp_q.size() != 0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (exp_q.size() != 0) begin
      err_count++;
    end
    report_and_stop();
  end
endmodule : testbench
